// *** design/csw_pkg.sv ***
// Package for the chip select and wait state decoder
package csw_pkg;

  // Register byte offsets; each select owns a 16-byte stride
  localparam logic [7:0] CSW_SEL_STRIDE     = 8'h10;
  localparam logic [3:0] CSW_OFF_CONTROL    = 4'h0;
  localparam logic [3:0] CSW_OFF_LOWER      = 4'h4;
  localparam logic [3:0] CSW_OFF_UPPER      = 4'h8;
  localparam logic [3:0] CSW_OFF_BUS_MODE   = 4'hc;
  localparam logic [7:0] CSW_OFF_STATUS     = 8'h40;

  // Control field positions
  localparam int CSW_CTL_EN_BIT    = 3;
  localparam int CSW_CTL_IO_BIT    = 4;
  localparam int CSW_CTL_WAIT_LSB  = 5;
  localparam int CSW_CTL_WAIT_MSB  = 7;

  // Bus mode field positions
  localparam int CSW_BM_CYC_LSB    = 0;
  localparam int CSW_BM_CYC_MSB    = 3;
  localparam int CSW_BM_MUX_BIT    = 4;
  localparam int CSW_BM_STYLE_LSB  = 6;
  localparam int CSW_BM_STYLE_MSB  = 7;

  // Reset values
  localparam logic [7:0] CSW_RST_CONTROL   = 8'h00;
  localparam logic [7:0] CSW_RST_LOWER     = 8'h00;
  localparam logic [7:0] CSW_RST_UPPER0    = 8'hff;
  localparam logic [7:0] CSW_RST_UPPER     = 8'h00;
  localparam logic [7:0] CSW_RST_BUS_MODE  = 8'h02;

  // On-chip peripheral I/O window
  localparam logic [15:0] CSW_PERIPH_LO    = 16'h0080;
  localparam logic [15:0] CSW_PERIPH_HI    = 16'h00ff;

  // Bus cycle time lower limit
  localparam logic [3:0] CSW_CYC_MIN       = 4'h1;

  localparam logic [1:0] CSW_RESP_OKAY     = 2'h0;
  localparam logic [1:0] CSW_RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0]
  {
    CSW_STYLE_NATIVE = 2'b00,
    CSW_STYLE_THREE  = 2'b01,
    CSW_STYLE_FOUR   = 2'b10,
    CSW_STYLE_SYNC   = 2'b11
  } csw_style_e;

  typedef enum logic [1:0]
  {
    CSW_ST_IDLE   = 2'b00,
    CSW_ST_WAIT   = 2'b01,
    CSW_ST_EXTW   = 2'b10,
    CSW_ST_DONE   = 2'b11
  } csw_state_e;

  // One processor bus access request
  typedef struct packed
  {
    logic        valid;
    logic        is_io;
    logic        is_write;
    logic [23:0] addr;
  } csw_access_s;

  // External bus strobes, all active low
  typedef struct packed
  {
    logic [3:0] select_n;
    logic       mem_n;
    logic       io_n;
    logic       rd_n;
    logic       wr_n;
  } csw_strobe_s;

endpackage

// *** design/csw_decoder.sv ***
// Chip select decoder with programmed and external wait states
`timescale 1ns/1ps
module csw_decoder
  import csw_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Processor access port
  input  wire csw_access_s cpu_access,
  output logic             cpu_stall,
  // External pins
  input  wire logic        wait_in_n,
  input  wire logic        bus_request_in_n,
  input  wire logic [23:0] ext_addr,
  input  wire logic        ext_is_io,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  output logic             bus_grant_out_n,
  output csw_strobe_s      strobe_reg,
  output logic [3:0]       mux_select_reg
);

  logic [7:0]  control_reg  [4];
  logic [7:0]  lower_reg    [4];
  logic [7:0]  upper_reg    [4];
  logic [7:0]  bus_mode_reg [4];

  // Pin synchronisers
  logic        wait_meta_reg;
  logic        wait_sync_reg;
  logic        breq_meta_reg;
  logic        breq_sync_reg;
  logic        erd_meta_reg;
  logic        erd_sync_reg;
  logic        ewr_meta_reg;
  logic        ewr_sync_reg;
  logic        eio_meta_reg;
  logic        eio_sync_reg;
  logic [23:0] eaddr_meta_reg;
  logic [23:0] eaddr_sync_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wait_meta_reg  <= 1'b1;
      wait_sync_reg  <= 1'b1;
      breq_meta_reg  <= 1'b1;
      breq_sync_reg  <= 1'b1;
      erd_meta_reg   <= 1'b1;
      erd_sync_reg   <= 1'b1;
      ewr_meta_reg   <= 1'b1;
      ewr_sync_reg   <= 1'b1;
      eio_meta_reg   <= 1'b0;
      eio_sync_reg   <= 1'b0;
      eaddr_meta_reg <= 24'h000000;
      eaddr_sync_reg <= 24'h000000;
    end
    else
    begin
      wait_meta_reg  <= wait_in_n;
      wait_sync_reg  <= wait_meta_reg;
      breq_meta_reg  <= bus_request_in_n;
      breq_sync_reg  <= breq_meta_reg;
      erd_meta_reg   <= ext_rd_n;
      erd_sync_reg   <= erd_meta_reg;
      ewr_meta_reg   <= ext_wr_n;
      ewr_sync_reg   <= ewr_meta_reg;
      eio_meta_reg   <= ext_is_io;
      eio_sync_reg   <= eio_meta_reg;
      eaddr_meta_reg <= ext_addr;
      eaddr_sync_reg <= eaddr_meta_reg;
    end
  end

  // Decode one select against an address
  function automatic logic sel_match(input logic [7:0] ctl,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi,
                                     input logic       is_io,
                                     input logic [23:0] a);
    logic hit;
    hit = 1'b0;
    if (ctl[CSW_CTL_EN_BIT])
    begin
      if (ctl[CSW_CTL_IO_BIT])
      begin
        hit = is_io && (a[15:8] == lo)
              && !((a[15:0] >= CSW_PERIPH_LO)
                   && (a[15:0] <= CSW_PERIPH_HI));
      end
      else
      begin
        hit = !is_io && (a[23:16] >= lo) && (a[23:16] <= hi);
      end
    end
    return hit;
  endfunction

  // Access source: internal processor or granted external master
  logic        granted_reg;
  csw_access_s cur;
  logic [3:0]  hits;
  logic [3:0]  onehot;
  logic [1:0]  win_idx;

  always_comb
  begin
    if (granted_reg)
    begin
      cur.valid    = !erd_sync_reg || !ewr_sync_reg;
      cur.is_io    = eio_sync_reg;
      cur.is_write = !ewr_sync_reg;
      cur.addr     = eaddr_sync_reg;
    end
    else
    begin
      cur = cpu_access;
    end
    for (int i = 0; i < 4; i++)
    begin
      hits[i] = cur.valid && sel_match(control_reg[i], lower_reg[i],
                                       upper_reg[i], cur.is_io, cur.addr);
    end
    onehot  = 4'h0;
    win_idx = 2'd0;
    if (hits[0])
    begin
      onehot = 4'h1;
    end
    else if (hits[1])
    begin
      onehot  = 4'h2;
      win_idx = 2'd1;
    end
    else if (hits[2])
    begin
      onehot  = 4'h4;
      win_idx = 2'd2;
    end
    else if (hits[3])
    begin
      onehot  = 4'h8;
      win_idx = 2'd3;
    end
  end

  // Bus grant; handed over only between processor accesses
  // Waiting for valid low too keeps a new access from starting with grant
  logic        grant_ok;

  assign grant_ok = !cpu_stall && !cpu_access.valid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      granted_reg     <= 1'b0;
      bus_grant_out_n <= 1'b1;
    end
    else
    begin
      granted_reg     <= !breq_sync_reg && (granted_reg || grant_ok);
      bus_grant_out_n <= !(!breq_sync_reg && (granted_reg || grant_ok));
    end
  end

  // Access sequencer
  csw_state_e state_reg;
  logic [2:0] wait_cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= CSW_ST_IDLE;
      wait_cnt_reg <= 3'd0;
      cpu_stall    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        CSW_ST_IDLE:
        begin
          if (!granted_reg && cur.valid && (onehot != 4'h0))
          begin
            wait_cnt_reg <= control_reg[win_idx][CSW_CTL_WAIT_MSB:
                                                 CSW_CTL_WAIT_LSB];
            state_reg    <= CSW_ST_WAIT;
            cpu_stall    <= 1'b1;
          end
        end
        CSW_ST_WAIT:
        begin
          if (wait_cnt_reg != 3'd0)
          begin
            wait_cnt_reg <= wait_cnt_reg - 3'd1;
          end
          // wait sampled at end of programmed waits
          else if (!wait_sync_reg)
          begin
            state_reg <= CSW_ST_EXTW;
          end
          else
          begin
            state_reg <= CSW_ST_DONE;
            cpu_stall <= 1'b0;
          end
        end
        CSW_ST_EXTW:
        begin
          if (wait_sync_reg)
          begin
            state_reg <= CSW_ST_DONE;
            cpu_stall <= 1'b0;
          end
        end
        CSW_ST_DONE:
        begin
          // Processor drops valid before the next access
          if (!cpu_access.valid)
          begin
            state_reg <= CSW_ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= CSW_ST_IDLE;
        end
      endcase
    end
  end

  // External strobes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strobe_reg     <= '{select_n: 4'hf, mem_n: 1'b1, io_n: 1'b1,
                          rd_n: 1'b1, wr_n: 1'b1};
      mux_select_reg <= 4'h0;
    end
    else
    begin
      strobe_reg.select_n <= ~onehot;
      strobe_reg.mem_n    <= !((onehot != 4'h0) && !cur.is_io);
      strobe_reg.io_n     <= !((onehot != 4'h0) && cur.is_io);
      strobe_reg.rd_n     <= !((onehot != 4'h0) && !cur.is_write);
      strobe_reg.wr_n     <= !((onehot != 4'h0) && cur.is_write);
      for (int i = 0; i < 4; i++)
      begin
        mux_select_reg[i] <= onehot[i] && bus_mode_reg[i][CSW_BM_MUX_BIT]
          && (bus_mode_reg[i][CSW_BM_STYLE_MSB:CSW_BM_STYLE_LSB]
              == CSW_STYLE_FOUR);
      end
    end
  end

  // AXI4-Lite slave; external master has no path to these
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  logic [1:0]  wsel;
  logic [3:0]  woff;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wsel    = aw_addr_reg[5:4];
  assign woff    = aw_addr_reg[3:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CSW_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg < CSW_OFF_STATUS && woff[1:0] == 2'b00)
                        ? CSW_RESP_OKAY : CSW_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_held_reg   <= 1'b0;
        w_held_reg    <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register file; only byte lane 0 carries data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        control_reg[i]  <= CSW_RST_CONTROL;
        lower_reg[i]    <= CSW_RST_LOWER;
        upper_reg[i]    <= (i == 0) ? CSW_RST_UPPER0 : CSW_RST_UPPER;
        bus_mode_reg[i] <= CSW_RST_BUS_MODE;
      end
    end
    else if (wr_fire && w_strb_reg[0] && aw_addr_reg < CSW_OFF_STATUS)
    begin
      if (woff == CSW_OFF_CONTROL)
      begin
        control_reg[wsel] <= w_data_reg[7:0];
      end
      else if (woff == CSW_OFF_LOWER)
      begin
        lower_reg[wsel] <= w_data_reg[7:0];
      end
      else if (woff == CSW_OFF_UPPER)
      begin
        upper_reg[wsel] <= w_data_reg[7:0];
      end
      else if (woff == CSW_OFF_BUS_MODE)
      begin
        // zero cycle count clamps to one
        bus_mode_reg[wsel] <= (w_data_reg[CSW_BM_CYC_MSB:CSW_BM_CYC_LSB]
                               == 4'h0)
          ? {w_data_reg[7:4], CSW_CYC_MIN} : w_data_reg[7:0];
      end
    end
  end

  // Read channel
  logic [1:0] rsel;
  logic [3:0] roff;
  logic [7:0] rbyte;
  logic       rok;

  assign rsel = s_axi_araddr[5:4];
  assign roff = s_axi_araddr[3:0];

  always_comb
  begin
    rbyte = 8'h00;
    rok   = 1'b1;
    if (s_axi_araddr == CSW_OFF_STATUS)
    begin
      rbyte = {granted_reg, cpu_stall, state_reg, ~strobe_reg.select_n};
    end
    else if (s_axi_araddr > CSW_OFF_STATUS)
    begin
      rok = 1'b0;
    end
    else if (roff == CSW_OFF_CONTROL)
    begin
      rbyte = control_reg[rsel];
    end
    else if (roff == CSW_OFF_LOWER)
    begin
      rbyte = lower_reg[rsel];
    end
    else if (roff == CSW_OFF_UPPER)
    begin
      rbyte = upper_reg[rsel];
    end
    else if (roff == CSW_OFF_BUS_MODE)
    begin
      rbyte = bus_mode_reg[rsel];
    end
    else
    begin
      rok = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= CSW_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rbyte};
      s_axi_rresp   <= rok ? CSW_RESP_OKAY : CSW_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // csw_decoder

// *** verif/csw_decoder_checker.sv ***
// Assertion checker for the chip select and wait decoder
`timescale 1ns/1ps
module csw_decoder_checker
  import csw_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Processor side
  input wire csw_access_s cpu_access,
  input wire logic        cpu_stall,
  // External pins
  input wire logic        wait_in_n,
  input wire logic        bus_request_in_n,
  input wire logic        bus_grant_out_n,
  input wire csw_strobe_s strobe_reg
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  reset_idle_a: assert property (disable iff (1'b0)
    !aresetn |=> &strobe_reg.select_n && bus_grant_out_n && !cpu_stall)
    else $error("outputs not idle after reset");
  one_select_a: assert property (
    $onehot0(~strobe_reg.select_n))
    else $error("more than one select low");
  space_excl_a: assert property (
    !(!strobe_reg.mem_n && !strobe_reg.io_n))
    else $error("memory and io request low together");
  sel_strobe_a: assert property (
    !(&strobe_reg.select_n) |->
      (strobe_reg.mem_n ^ strobe_reg.io_n) &&
      (strobe_reg.rd_n ^ strobe_reg.wr_n))
    else $error("select low without one request and one strobe");
  periph_io_a: assert property (
    cpu_access.valid && cpu_access.is_io && bus_grant_out_n &&
    cpu_access.addr[15:7] == 9'h001 |=> &strobe_reg.select_n)
    else $error("select low in peripheral io range");
  idle_high_a: assert property (
    !cpu_access.valid && bus_grant_out_n ##1 bus_grant_out_n
    |-> &strobe_reg.select_n)
    else $error("select low with no access");
  // Waiting on the pin is excused, not timed
  stall_bound_a: assert property (
    $rose(cpu_stall) |-> ##[1:14] (!cpu_stall || !wait_in_n))
    else $error("stall longer than programmed waits");
  grant_nostall_a: assert property (
    !bus_grant_out_n |-> !cpu_stall)
    else $error("stall while bus is granted");
  grant_take_a: assert property (
    (!bus_request_in_n && !cpu_access.valid)[*6] |-> !bus_grant_out_n)
    else $error("bus request not granted");

  cover property ($rose(cpu_stall));
  cover property (!bus_grant_out_n && !(&strobe_reg.select_n));
  cover property (!strobe_reg.io_n && !(&strobe_reg.select_n));
endmodule // csw_decoder_checker

bind csw_decoder csw_decoder_checker u_csw_decoder_checker
(
  .aclk,
  .aresetn,
  .cpu_access,
  .cpu_stall,
  .wait_in_n,
  .bus_request_in_n,
  .bus_grant_out_n,
  .strobe_reg
);

// *** verif/csw_ext_device.sv ***
// External peripheral model that stretches accesses by its wait pin
`timescale 1ns/1ps
module csw_ext_device
  import csw_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bus from the decoder, hold length from the bench
  input  wire csw_strobe_s strobe,
  input  wire logic [3:0]  hold_cycles,
  // Wait pin back to the decoder
  output logic             wait_in_n
);
  logic [3:0] left_reg;
  logic       seen_reg;

  // wait raised in first waited cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || &strobe.select_n)
    begin
      left_reg <= 4'h0;
      seen_reg <= 1'h0;
    end
    else if (!seen_reg)
    begin
      left_reg <= hold_cycles;
      seen_reg <= 1'h1;
    end
    else if (left_reg != 4'h0)
      left_reg <= left_reg - 4'h1;
  end

  // Pull-up brings the pin high once released
  assign wait_in_n = (left_reg == 4'h0);
endmodule // csw_ext_device

// *** verif/chip_select_wait_decoder_test.sv ***
// Self-checking bench for the chip select and wait decoder
`timescale 1ns/1ps
module chip_select_wait_decoder_test
  import csw_pkg::*;
();
  typedef struct packed
  {
    logic        io;
    logic        wr;
    logic [23:0] a;
    logic [3:0]  sel;
  } csw_row_s;
  localparam logic [1:0] rsp_ok = CSW_RESP_OKAY;
  logic        aclk, aresetn, cpu_stall, wait_in_n, bus_grant_out_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, mux_select_reg, hold_cycles, seen_mux;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        bus_request_in_n, ext_is_io, ext_rd_n, ext_wr_n;
  logic [23:0] ext_addr;
  csw_access_s cpu_access;
  csw_strobe_s strobe_reg, seen;
  int          err_total, checks, cycles, n, base;
  logic [15:0] cfg[6] = '{16'h087f, 16'h1008, 16'h189f,
                          16'h2018, 16'h2412, 16'h3018};
  csw_row_s    rows[12] = '{
    '{1'h0, 1'h0, 24'h123456, 4'he}, '{1'h0, 1'h1, 24'h7fffff, 4'he},
    '{1'h0, 1'h0, 24'h800000, 4'hd}, '{1'h0, 1'h1, 24'h9fffff, 4'hd},
    '{1'h0, 1'h0, 24'ha00000, 4'hf}, '{1'h1, 1'h0, 24'hff1234, 4'hb},
    '{1'h1, 1'h1, 24'h0012ab, 4'hb}, '{1'h1, 1'h0, 24'h000040, 4'h7},
    '{1'h1, 1'h0, 24'h000080, 4'hf}, '{1'h1, 1'h1, 24'h0000ff, 4'hf},
    '{1'h0, 1'h0, 24'h001200, 4'he}, '{1'h1, 1'h0, 24'h7f007f, 4'h7}};

  csw_decoder u_csw_decoder
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_access, .cpu_stall, .wait_in_n,
    .bus_request_in_n, .ext_addr, .ext_is_io, .ext_rd_n, .ext_wr_n,
    .bus_grant_out_n, .strobe_reg, .mux_select_reg
  );

  csw_ext_device u_csw_ext_device
  (
    .aclk, .aresetn, .strobe(strobe_reg), .hold_cycles, .wait_in_n
  );

  initial
  begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(rsp_ok));
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    chk(s_axi_rdata, d);
    chk(32'(s_axi_rresp), 32'(r));
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  // Strobes captured once the decode has landed
  task automatic access(input logic io, input logic wr,
                        input logic [23:0] a);
    cpu_access <= '{1'h1, io, wr, a};
    n = 0;
    @(posedge aclk);
    @(posedge aclk);
    seen = strobe_reg;
    seen_mux = mux_select_reg;
    while (cpu_stall)
    begin
      n++;
      @(posedge aclk);
    end
    cpu_access.valid <= 1'h0;
    @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, hold_cycles} = '0;
    s_axi_wstrb = 4'hf;
    cpu_access = '0;
    {bus_request_in_n, ext_rd_n, ext_wr_n, ext_is_io} = 4'he;
    ext_addr = 24'h0;
    aresetn = 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(8'(i * 16), 32'h0, rsp_ok);
      reg_rd(8'(i * 16 + 4), 32'h0, rsp_ok);
      reg_rd(8'(i * 16 + 8), (i == 0) ? 32'hff : 32'h0, rsp_ok);
      reg_rd(8'(i * 16 + 12), 32'h2, rsp_ok);
    end
    access(1'h0, 1'h0, 24'habcdef);
    chk(32'(seen.select_n), 32'hf);
    axi_wr(8'h00, 8'h08);
    access(1'h0, 1'h0, 24'hfedcba);
    chk(32'(seen.select_n), 32'he);
    reg_rd(8'h44, 32'h0, CSW_RESP_SLVERR);
    foreach (cfg[i])
      axi_wr(cfg[i][15:8], cfg[i][7:0]);
    foreach (rows[i])
    begin
      access(rows[i].io, rows[i].wr, rows[i].a);
      chk(32'(seen.select_n), 32'(rows[i].sel));
      if (rows[i].sel != 4'hf)
        chk(32'({seen.mem_n, seen.io_n, seen.rd_n, seen.wr_n}), 32'({
          rows[i].io, ~rows[i].io, rows[i].wr, ~rows[i].wr}));
    end
    for (int w = 0; w < 8; w++)
    begin
      axi_wr(8'h00, 8'(w * 32 + 8));
      access(1'h0, 1'h0, 24'h010000);
      if (w == 0)
        base = n;
      chk(32'(n), 32'(base + w));
    end
    hold_cycles <= 4'h9;
    access(1'h0, 1'h1, 24'h020000);
    chk(32'(n > base + 7), 32'h1);
    hold_cycles <= 4'h0;
    axi_wr(8'h1c, {CSW_STYLE_FOUR, 6'h12});
    axi_wr(8'h2c, 8'h00);
    reg_rd(8'h2c, 32'h1, rsp_ok);
    reg_rd(8'h1c, 32'h92, rsp_ok);
    access(1'h0, 1'h0, 24'h800000);
    chk(32'(seen_mux), 32'h2);
    ext_addr <= 24'h850000;
    ext_rd_n <= 1'h0;
    bus_request_in_n <= 1'h0;
    while (bus_grant_out_n)
      @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk(32'(strobe_reg.select_n), 32'hd);
    chk(32'(cpu_stall), 32'h0);
    reg_rd(8'h40, 32'h82, rsp_ok);
    ext_rd_n <= 1'h1;
    repeat (4) @(posedge aclk);
    bus_request_in_n <= 1'h1;
    repeat (6) @(posedge aclk);
    chk(32'(bus_grant_out_n), 32'h1);
    tally_and_finish();
  end
endmodule // chip_select_wait_decoder_test
